// >>> hdl/afr_cfg.svh
// constants of the frame readout and conversion control block
// assumes a 20 MHz master clock; every timing count is in master-clock cycles, opcode edge counts in serial falls
`ifndef AFR_CFG_SVH
`define AFR_CFG_SVH

// frame layout
`define AFR_FRAME_BITS        8'd152
`define AFR_FRAME_LAST        8'd151
`define AFR_FRAME_STOP        8'd152
`define AFR_STATUS_HEAD       4'hC
`define AFR_CHANNELS          8

// settling time per rate code, in master-clock cycles
`define AFR_SETTLE_R0         17'd1160
`define AFR_SETTLE_R1         17'd2312
`define AFR_SETTLE_R2         17'd4616
`define AFR_SETTLE_R3         17'd9224
`define AFR_SETTLE_R4         17'd18440
`define AFR_SETTLE_R5         17'd36872
`define AFR_SETTLE_R6         17'd73736
// settling spans four data periods plus this overhead
`define AFR_PERIOD_OVERHEAD   17'd8

// control timing, in master-clock cycles
`define AFR_INIT_CYCLES       17'd18
`define AFR_STATUS_LEAD       17'd2
`define AFR_START_MIN         2'd2
`define AFR_WAKE_CYCLES       17'd4096

// opcodes: start and stop act at the 7th falling edge, reset at the 8th
`define AFR_OP_START          8'h10
`define AFR_OP_STOP           8'h12
`define AFR_OP_RESET          8'h16
`define AFR_FALL_SYSTEM       3'd6
`define AFR_FALL_RESET        3'd7

// register defaults and field positions
`define AFR_CONFIG_ONE_RST    8'h06
`define AFR_CONFIG_FOUR_RST   8'h00
`define AFR_BREATHING_RST     8'h00
`define AFR_GPIO_DIR_RST      4'hF
`define AFR_GPIO_OUT_RST      4'h0
`define AFR_RATE_MSB          2
`define AFR_CHAIN_EN_BIT      6
`define AFR_ONE_SHOT_BIT      3

`endif

// >>> hdl/afr_pkg.sv
// types of the frame readout and conversion control block
// assumes afr_cfg.svh supplies the numeric constants
package afr_pkg;

  // 24-bit status word at the head of every frame
  typedef struct packed {
    logic [3:0] head;
    logic [7:0] pos_flags;
    logic [7:0] neg_flags;
    logic [3:0] gpio;
  } afr_status_type;

  // eight 16-bit two's complement channel words, element 7 first
  typedef logic [7:0][15:0] afr_chan_type;

  // a whole frame, most significant bit shifted out first
  typedef struct packed {
    afr_status_type status;
    afr_chan_type   chan;
  } afr_frame_type;

  // conversion control states
  typedef enum logic [2:0] {
    AFR_ST_INIT    = 3'b000,
    AFR_ST_IDLE    = 3'b001,
    AFR_ST_SETTLE  = 3'b010,
    AFR_ST_CONVERT = 3'b011,
    AFR_ST_HOLD    = 3'b100,
    AFR_ST_SLEEP   = 3'b101,
    AFR_ST_WAKE    = 3'b110
  } afr_state_type;

endpackage

// >>> hdl/afr_pin_sync.sv
// three-stage synchroniser with agreement filter for asynchronous inputs
// assumes a synchronous active-high reset on the sampling clock
`timescale 1ns/1ns
module afr_pin_sync #(
  parameter int          WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset,
  // raw and filtered levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] level
);

  genvar i;

  // per bit: stage one feeds stage two only; the level follows two and three
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      always_ff @(posedge clk)
      begin
        if (reset)
        begin
          stage1 <= RESET_VAL[i];
          stage2 <= RESET_VAL[i];
          stage3 <= RESET_VAL[i];
          level[i] <= RESET_VAL[i];
        end
        else
        begin
          stage1 <= async_in[i];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3)
            level[i] <= stage3;
        end
      end
    end
  endgenerate

endmodule

// >>> hdl/afr_readout_ctrl.sv
// conversion control, frame capture and serial readout of a converter
// assumes SCLK comes from the host, CS_N high between transfers, and
// channel words and electrode flags come from the converter path on MCLK
//
// Notes on behaviour
// RULE1: output changes on rising edge, off when deselected
// RULE2: host starts conversions before reading data
// RULE3: MSB on first rising edge; ready rises
// RULE4: host keeps data input low while reading
// RULE5: frame is status word plus eight channels
// RULE6: status is 1100, electrode flags, pin levels
// RULE7: disabled channels read zero, slot kept
// RULE8: status captured two cycles before ready falls
// RULE9: chain enable repeats frame on extra clocks
// RULE10: ready falls on new data, ignoring select
// RULE11: first falling serial edge raises ready
// RULE12: four pins, direction bits, writes to inputs ignored
// RULE13: power-down pin stops all; wake delay after
// RULE14: pin or opcode reset restores defaults, restarts
// RULE15: new first-config or breathing value resets filter
// RULE16: convert only after start two cycles or opcode
// RULE17: bit 3 of config four picks one-shot
// RULE18: start raises ready; first fall after settling
// RULE19: step settles after three periods, fourth pulse
// RULE20: stop lets running conversion finish, then halts
// RULE21: start and stop act at seventh falling edge
// RULE22: host retriggers start when leaving one-shot
// RULE23: data input sampled on falling serial edge
// RULE24: deselect resets serial state, ignores clock, data; serial falls while deselected still raise ready
// RULE25: one-shot holds ready low until retriggered; serial falls in hold still raise ready
`timescale 1ns/1ns
`include "afr_cfg.svh"
module afr_readout_ctrl #(
  parameter logic [16:0] SETTLE_R0   = `AFR_SETTLE_R0,
  parameter logic [16:0] SETTLE_R1   = `AFR_SETTLE_R1,
  parameter logic [16:0] SETTLE_R2   = `AFR_SETTLE_R2,
  parameter logic [16:0] SETTLE_R3   = `AFR_SETTLE_R3,
  parameter logic [16:0] SETTLE_R4   = `AFR_SETTLE_R4,
  parameter logic [16:0] SETTLE_R5   = `AFR_SETTLE_R5,
  parameter logic [16:0] SETTLE_R6   = `AFR_SETTLE_R6,
  parameter logic [16:0] WAKE_CYCLES = `AFR_WAKE_CYCLES
) (
  // master clock and reset
  input  wire logic               MCLK,
  input  wire logic               RESET,
  // serial link
  input  wire logic               SCLK,
  input  wire logic               CS_N,
  input  wire logic               DIN,
  output logic                    DOUT,
  output logic                    DOUT_OE,
  output logic                    CONVERSION_READY_N,
  // conversion control pins
  input  wire logic               START,
  input  wire logic               POWER_DOWN_N,
  // converter path
  input  wire afr_pkg::afr_chan_type CHANNEL_DATA,
  input  wire logic [7:0]         CHANNEL_ENABLE,
  input  wire logic [7:0]         ELECTRODE_OFF_POS_FLAGS,
  input  wire logic [7:0]         ELECTRODE_OFF_NEG_FLAGS,
  // general-purpose pins
  input  wire logic [3:0]         GPIO_IN,
  output logic      [3:0]         GPIO_OUT,
  output logic      [3:0]         GPIO_OE,
  // register writes
  input  wire logic               GPIO_WRITE,
  input  wire logic [3:0]         GPIO_DIR_WDATA,
  input  wire logic [3:0]         GPIO_LEVEL_WDATA,
  input  wire logic               CONFIG_ONE_WRITE,
  input  wire logic               CONFIG_FOUR_WRITE,
  input  wire logic               BREATHING_WRITE,
  input  wire logic [7:0]         REG_WDATA,
  // register contents and state
  output logic      [3:0]         PIN_DIRECTION_BITS,
  output logic      [3:0]         PIN_LEVEL_BITS,
  output logic      [7:0]         CONFIG_REG_ONE,
  output logic      [7:0]         CONFIG_REG_FOUR,
  output logic      [7:0]         BREATHING_CTRL,
  output logic                    CONVERTING,
  output logic                    POWERED_DOWN
);

  localparam logic [7:0] op_start = `AFR_OP_START;
  localparam logic [7:0] op_stop  = `AFR_OP_STOP;
  localparam logic [7:0] op_reset = `AFR_OP_RESET;

  // link domain state
  logic [7:0]              out_idx;
  logic [6:0]              in_shift;
  logic [2:0]              fall_cnt;
  logic                    tog_start;
  logic                    tog_stop;
  logic                    tog_reset;
  logic                    tog_fall;
  // synchronised levels
  logic [9:0]              sync_level;
  logic                    start_lvl;
  logic                    power_down_n_lvl;
  logic                    sclk_lvl;
  logic [3:0]              gpio_lvl;
  logic                    tog_start_lvl;
  logic                    tog_stop_lvl;
  logic                    tog_reset_lvl;
  // master domain state
  afr_pkg::afr_state_type  state;
  afr_pkg::afr_state_type  next_state;
  logic [16:0]             cnt;
  logic [16:0]             next_cnt;
  logic                    ready_n;
  logic                    next_ready_n;
  logic                    run_cmd;
  logic                    next_run_cmd;
  logic [1:0]              start_hi_cnt;
  logic                    start_ok_q;
  logic                    sclk_q;
  logic                    tog_start_q;
  logic                    tog_stop_q;
  logic                    tog_reset_q;
  logic [7:0]              config_one;
  logic [7:0]              config_four;
  logic [7:0]              breathing;
  logic [3:0]              gpio_dir;
  logic [3:0]              gpio_out;
  afr_pkg::afr_status_type status_q;
  afr_pkg::afr_chan_type   chan_q;
  afr_pkg::afr_chan_type   chan_masked;
  afr_pkg::afr_frame_type  frame;
  logic                    capture_status;
  logic                    load_frame;

  // serial decode wires
  wire [6:0]  seven_bits  = {in_shift[5:0], DIN};
  wire [7:0]  eight_bits  = {in_shift, DIN};
  wire        hit_start   = (fall_cnt == `AFR_FALL_SYSTEM) &&
                            (seven_bits == op_start[7:1]);
  wire        hit_stop    = (fall_cnt == `AFR_FALL_SYSTEM) &&
                            (seven_bits == op_stop[7:1]);
  wire        hit_reset   = (fall_cnt == `AFR_FALL_RESET) &&
                            (eight_bits == op_reset);
  wire [151:0] frame_flat = frame;
  wire [7:0]  bit_sel     = `AFR_FRAME_LAST - out_idx;
  wire        in_frame    = (out_idx < `AFR_FRAME_BITS);
  wire        chain_en    = config_one[`AFR_CHAIN_EN_BIT];

  // output shifter on rising serial edges, cleared while deselected
  always_ff @(posedge SCLK or posedge CS_N)
  begin
    if (CS_N)
    begin
      out_idx <= 8'h00; // RULE24
      DOUT    <= 1'b0;
    end
    else
    begin
      DOUT <= in_frame ? frame_flat[bit_sel] : 1'b0; // RULE1 RULE3
      if (out_idx == `AFR_FRAME_LAST)
        out_idx <= chain_en ? 8'h00 : `AFR_FRAME_STOP; // RULE9
      else if (in_frame)
        out_idx <= out_idx + 8'h01;
    end
  end

  // the pin drives only while selected
  assign DOUT_OE = ~CS_N; // RULE1

  // opcode shifter on falling serial edges, cleared while deselected
  always_ff @(negedge SCLK or posedge CS_N)
  begin
    if (CS_N)
    begin
      in_shift <= 7'h00; // RULE24
      fall_cnt <= 3'h0;
    end
    else
    begin
      in_shift <= seven_bits; // RULE23
      fall_cnt <= fall_cnt + 3'h1;
    end
  end

  // serial falls and opcode events become toggles for the master domain;
  // a toggle outlasts the filter, a short serial clock level does not;
  // the decodes stay low while deselected, so only the fall toggle moves
  always_ff @(negedge SCLK or posedge RESET)
  begin
    if (RESET)
    begin
      tog_fall  <= 1'b0;
      tog_start <= 1'b0;
      tog_stop  <= 1'b0;
      tog_reset <= 1'b0;
    end
    else
    begin
      tog_fall  <= ~tog_fall; // RULE11
      tog_start <= tog_start ^ hit_start; // RULE21
      tog_stop  <= tog_stop ^ hit_stop; // RULE21
      tog_reset <= tog_reset ^ hit_reset; // RULE14
    end
  end

  // pins and toggles into the master domain
  afr_pin_sync #(
    .WIDTH     (10),
    .RESET_VAL (10'h002)
  ) u_sync (
    .clk      (MCLK),
    .reset    (RESET),
    .async_in ({tog_reset, tog_stop, tog_start, GPIO_IN,
                tog_fall, POWER_DOWN_N, START}),
    .level    (sync_level)
  );

  assign start_lvl     = sync_level[0];
  assign power_down_n_lvl      = sync_level[1];
  assign sclk_lvl      = sync_level[2]; // flips on each serial fall
  assign gpio_lvl      = sync_level[6:3];
  assign tog_start_lvl = sync_level[7];
  assign tog_stop_lvl  = sync_level[8];
  assign tog_reset_lvl = sync_level[9];

  // events seen in the master domain
  wire start_op   = tog_start_lvl ^ tog_start_q;
  wire stop_op    = tog_stop_lvl ^ tog_stop_q;
  wire reset_op   = tog_reset_lvl ^ tog_reset_q;
  wire sclk_fall  = sclk_q ^ sclk_lvl;
  wire start_ok   = (start_hi_cnt == `AFR_START_MIN); // RULE16
  wire pin_rise   = start_ok & ~start_ok_q;
  wire trigger    = start_op | pin_rise;
  wire go         = start_ok | run_cmd; // RULE16
  wire one_shot   = config_four[`AFR_ONE_SHOT_BIT]; // RULE17
  wire [2:0] rate = config_one[`AFR_RATE_MSB:0];
  wire filt_reset = (CONFIG_ONE_WRITE && (REG_WDATA != config_one)) ||
                    (BREATHING_WRITE && (REG_WDATA != breathing)); // RULE15

  // settling and data period per rate code; unprinted code 7 runs slowest
  wire [16:0] settle_sel =
    (rate == 3'h0) ? SETTLE_R0 :
    (rate == 3'h1) ? SETTLE_R1 :
    (rate == 3'h2) ? SETTLE_R2 :
    (rate == 3'h3) ? SETTLE_R3 :
    (rate == 3'h4) ? SETTLE_R4 :
    (rate == 3'h5) ? SETTLE_R5 : SETTLE_R6; // RULE18
  wire [16:0] period_sel = (settle_sel - `AFR_PERIOD_OVERHEAD) >> 2; // RULE19

  // edge and toggle history
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      sclk_q       <= 1'b0;
      tog_start_q  <= 1'b0;
      tog_stop_q   <= 1'b0;
      tog_reset_q  <= 1'b0;
      start_hi_cnt <= 2'h0;
      start_ok_q   <= 1'b0;
    end
    else
    begin
      sclk_q       <= sclk_lvl;
      tog_start_q  <= tog_start_lvl;
      tog_stop_q   <= tog_stop_lvl;
      tog_reset_q  <= tog_reset_lvl;
      start_ok_q   <= start_ok;
      if (!start_lvl)
        start_hi_cnt <= 2'h0;
      else if (!start_ok)
        start_hi_cnt <= start_hi_cnt + 2'h1;
    end
  end

  // conversion sequencing
  always_comb
  begin
    next_state     = state;
    next_cnt       = (cnt != 17'h00000) ? cnt - 17'h00001 : cnt;
    next_ready_n   = (sclk_fall || (cnt == `AFR_STATUS_LEAD)) ?
                     1'b1 : ready_n; // RULE3 RULE10 RULE11
    next_run_cmd   = (run_cmd | start_op) & ~stop_op; // RULE20
    capture_status = 1'b0;
    load_frame     = 1'b0;
    if (reset_op)
    begin
      next_state   = afr_pkg::AFR_ST_INIT; // RULE14
      next_cnt     = `AFR_INIT_CYCLES;
      next_ready_n = 1'b1;
      next_run_cmd = 1'b0;
    end
    else if (!power_down_n_lvl)
    begin
      next_state   = afr_pkg::AFR_ST_SLEEP; // RULE13
      next_ready_n = 1'b1;
      next_run_cmd = 1'b0;
    end
    else
    begin
      unique case (state)
        afr_pkg::AFR_ST_INIT:
        begin
          next_ready_n = 1'b1;
          if (cnt == 17'h00000)
            next_state = afr_pkg::AFR_ST_IDLE;
        end
        afr_pkg::AFR_ST_IDLE:
        begin
          if (go)
          begin
            next_state   = afr_pkg::AFR_ST_SETTLE; // RULE18
            next_cnt     = settle_sel;
            next_ready_n = 1'b1;
          end
        end
        afr_pkg::AFR_ST_SETTLE,
        afr_pkg::AFR_ST_CONVERT:
        begin
          if (filt_reset || trigger)
          begin
            next_state   = afr_pkg::AFR_ST_SETTLE; // RULE15
            next_cnt     = settle_sel;
            next_ready_n = 1'b1;
          end
          else if (cnt == 17'h00000)
          begin
            load_frame   = 1'b1;
            next_ready_n = 1'b0; // RULE10
            if (one_shot)
              next_state = afr_pkg::AFR_ST_HOLD; // RULE25
            else if (go)
            begin
              next_state = afr_pkg::AFR_ST_CONVERT;
              next_cnt   = period_sel;
            end
            else
              next_state = afr_pkg::AFR_ST_IDLE; // RULE20
          end
          else if (cnt == `AFR_STATUS_LEAD)
            capture_status = 1'b1; // RULE8
        end
        afr_pkg::AFR_ST_HOLD:
        begin
          if (trigger)
          begin
            next_state   = afr_pkg::AFR_ST_SETTLE; // RULE25
            next_cnt     = settle_sel;
            next_ready_n = 1'b1;
          end
        end
        afr_pkg::AFR_ST_SLEEP:
        begin
          next_ready_n = 1'b1;
          next_state   = afr_pkg::AFR_ST_WAKE; // RULE13
          next_cnt     = WAKE_CYCLES;
        end
        afr_pkg::AFR_ST_WAKE:
        begin
          next_ready_n = 1'b1;
          if (cnt == 17'h00000)
            next_state = afr_pkg::AFR_ST_IDLE;
        end
        default:
        begin
          next_state   = afr_pkg::AFR_ST_INIT;
          next_cnt     = `AFR_INIT_CYCLES;
          next_ready_n = 1'b1;
        end
      endcase
    end
  end

  // sequencer registers
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      state   <= afr_pkg::AFR_ST_INIT; // RULE14
      cnt     <= `AFR_INIT_CYCLES;
      ready_n <= 1'b1;
      run_cmd <= 1'b0;
    end
    else
    begin
      state   <= next_state;
      cnt     <= next_cnt;
      ready_n <= next_ready_n;
      run_cmd <= next_run_cmd;
    end
  end

  // channel words of disabled slots read zero
  genvar ch;
  generate
    for (ch = 0; ch < `AFR_CHANNELS; ch++)
    begin : g_chan
      assign chan_masked[ch] = CHANNEL_ENABLE[ch] ?
                               CHANNEL_DATA[ch] : 16'h0000; // RULE7
    end
  endgenerate

  // status captured ahead of the ready fall, channels at it
  always_ff @(posedge MCLK)
  begin
    if (RESET)
    begin
      status_q <= '0;
      chan_q   <= '0;
    end
    else
    begin
      if (capture_status)
        status_q <= {`AFR_STATUS_HEAD, ELECTRODE_OFF_POS_FLAGS,
                     ELECTRODE_OFF_NEG_FLAGS, gpio_lvl}; // RULE6 RULE8
      if (load_frame)
        chan_q <= chan_masked;
    end
  end

  // frame seen by the link; its status changes two cycles before a ready fall, its channels at it
  assign frame = {status_q, chan_q}; // RULE5

  // configuration and pin registers, defaults on either reset
  always_ff @(posedge MCLK)
  begin
    if (RESET || reset_op)
    begin
      config_one  <= `AFR_CONFIG_ONE_RST; // RULE14
      config_four <= `AFR_CONFIG_FOUR_RST;
      breathing   <= `AFR_BREATHING_RST;
      gpio_dir    <= `AFR_GPIO_DIR_RST; // RULE12
      gpio_out    <= `AFR_GPIO_OUT_RST;
    end
    else
    begin
      if (CONFIG_ONE_WRITE)
        config_one <= REG_WDATA;
      if (CONFIG_FOUR_WRITE)
        config_four <= REG_WDATA;
      if (BREATHING_WRITE)
        breathing <= REG_WDATA;
      if (GPIO_WRITE)
      begin
        gpio_dir <= GPIO_DIR_WDATA;
        gpio_out <= (GPIO_LEVEL_WDATA & ~GPIO_DIR_WDATA) |
                    (gpio_out & GPIO_DIR_WDATA); // RULE12
      end
    end
  end

  // pin drive: direction bit low means output
  assign GPIO_OE            = ~gpio_dir; // RULE12
  assign GPIO_OUT           = gpio_out;
  assign PIN_DIRECTION_BITS = gpio_dir;
  assign PIN_LEVEL_BITS     = gpio_lvl; // RULE12
  assign CONFIG_REG_ONE     = config_one;
  assign CONFIG_REG_FOUR    = config_four;
  assign BREATHING_CTRL     = breathing;

  // status outputs
  assign CONVERSION_READY_N = ready_n;
  assign CONVERTING   = (state == afr_pkg::AFR_ST_SETTLE) ||
                        (state == afr_pkg::AFR_ST_CONVERT);
  assign POWERED_DOWN = (state == afr_pkg::AFR_ST_SLEEP) ||
                        (state == afr_pkg::AFR_ST_WAKE);

endmodule

// >>> verif/afr_host_model.sv
// host model: serial master shifting opcodes in, frames out
// assumes the bench calls xfer from its main thread
`timescale 1ns/1ns
module afr_host_model (
  // serial link
  output logic         sclk,
  output logic         cs_n,
  output logic         din,
  input  wire logic    dout,
  // bits read back, last one lowest
  output logic [159:0] rx
);
  // idle: clock parked low, deselected
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din = 1'b1;
    rx = '0;
  end
  // opcode MSB first, then n bits read before each fall
  task automatic xfer(input logic [7:0] op, input int n);
    cs_n = 1'b0;
    #213;
    for (int i = 0; i < n; i++)
    begin
      #80 sclk = 1'b1;
      din = (i < 8) ? op[7-i] : 1'b0;
      #80 rx = {rx[158:0], dout};
      sclk = 1'b0;
    end
    #400 cs_n = 1'b1;
    din = ~din;
    #160;
  endtask
endmodule

// >>> verif/afr_readout_ctrl_assertions.sv
// port checker of the readout control block
// assumes binding into afr_readout_ctrl, all on MCLK
`timescale 1ns/1ns
module afr_readout_ctrl_assertions (
  input wire logic       MCLK, RESET, SCLK, CS_N, DOUT, DOUT_OE,
  input wire logic       CONVERSION_READY_N, POWER_DOWN_N,
  input wire logic       GPIO_WRITE, CONFIG_FOUR_WRITE,
  input wire logic       CONVERTING, POWERED_DOWN,
  input wire logic [3:0] GPIO_OUT, GPIO_OE, GPIO_DIR_WDATA,
  input wire logic [3:0] GPIO_LEVEL_WDATA, PIN_DIRECTION_BITS,
  input wire logic [7:0] REG_WDATA, CONFIG_REG_ONE, CONFIG_REG_FOUR
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RESET);
  // serial output
  property p_off; CS_N |-> !DOUT && !DOUT_OE; endproperty
  a_off: assert property (p_off)
    else $error("dout active while deselected");
  property p_edge;
    !CS_N && $past(!CS_N) && $changed(DOUT) |-> $rose(SCLK);
  endproperty
  a_edge: assert property (p_edge)
    else $error("dout changed off rising edge");
  // ready output
  property p_rise; $fell(SCLK) |-> ##[0:7] CONVERSION_READY_N; endproperty
  a_rise: assert property (p_rise)
    else $error("ready not raised by serial clock");
  property p_src; $fell(CONVERSION_READY_N) |-> $past(CONVERTING); endproperty
  a_src: assert property (p_src)
    else $error("ready fell without conversion");
  property p_start;
    $rose(CONVERTING) |-> ##[0:2] CONVERSION_READY_N [*8];
  endproperty
  a_start: assert property (p_start)
    else $error("ready not high at start");
  property p_shot;
    CONFIG_REG_FOUR[3] && $fell(CONVERSION_READY_N) |-> ##[0:2] !CONVERTING;
  endproperty
  a_shot: assert property (p_shot)
    else $error("one-shot kept converting");
  // pins, registers, power
  property p_rst;
    $fell(RESET) |-> PIN_DIRECTION_BITS == 4'hF && GPIO_OE == 4'h0
      && CONFIG_REG_ONE == 8'h06;
  endproperty
  a_rst: assert property (p_rst)
    else $error("reset values wrong");
  property p_dir;
    GPIO_WRITE |=> PIN_DIRECTION_BITS == $past(GPIO_DIR_WDATA)
      && GPIO_OE == ~PIN_DIRECTION_BITS;
  endproperty
  a_dir: assert property (p_dir)
    else $error("direction write wrong");
  property p_out;
    GPIO_WRITE |=> ((GPIO_OUT ^ $past(GPIO_LEVEL_WDATA)) & GPIO_OE) == 4'h0;
  endproperty
  a_out: assert property (p_out)
    else $error("output level write wrong");
  property p_cfg4; CONFIG_FOUR_WRITE |=> CONFIG_REG_FOUR == $past(REG_WDATA);
  endproperty
  a_cfg4: assert property (p_cfg4)
    else $error("config four write wrong");
  property p_pd; POWER_DOWN_N == 1'b0 [*8] |-> POWERED_DOWN; endproperty
  a_pd: assert property (p_pd)
    else $error("power-down not entered");
endmodule
bind afr_readout_ctrl afr_readout_ctrl_assertions chk (
  .MCLK(MCLK), .RESET(RESET), .SCLK(SCLK), .CS_N(CS_N), .DOUT(DOUT),
  .DOUT_OE(DOUT_OE), .CONVERSION_READY_N(CONVERSION_READY_N),
  .POWER_DOWN_N(POWER_DOWN_N), .GPIO_WRITE(GPIO_WRITE),
  .CONFIG_FOUR_WRITE(CONFIG_FOUR_WRITE), .CONVERTING(CONVERTING),
  .POWERED_DOWN(POWERED_DOWN), .GPIO_OUT(GPIO_OUT), .GPIO_OE(GPIO_OE),
  .GPIO_DIR_WDATA(GPIO_DIR_WDATA), .GPIO_LEVEL_WDATA(GPIO_LEVEL_WDATA),
  .PIN_DIRECTION_BITS(PIN_DIRECTION_BITS), .REG_WDATA(REG_WDATA),
  .CONFIG_REG_ONE(CONFIG_REG_ONE), .CONFIG_REG_FOUR(CONFIG_REG_FOUR));

// >>> verif/afr_readout_ctrl_tb.sv
// self-checking bench of the readout control block
// assumes the host model drives the link; settle and wake shortened
`timescale 1ns/1ns
module afr_readout_ctrl_tb;
  localparam int SETTLE = 64;
  logic mclk = 1'b0, reset = 1'b1, start = 1'b0, pd_n = 1'b1;
  logic sclk, cs_n, din, dout, oe, rdy_n, conv, pdd, rdy_q;
  logic gw = 1'b0, w1 = 1'b0, w4 = 1'b0, wb = 1'b0;
  logic [3:0] dir_wd = '0, lvl_wd = '0, ext = '0, pins, g_out, g_oe;
  logic [3:0] dir, lvl, mo = '0;
  logic [7:0] wd = '0, en = '1, pos = '0, neg = '0, c1, c4, br;
  logic [159:0] rx;
  logic [151:0] ef;
  afr_pkg::afr_chan_type chan = '0;
  int errors = 0, comparisons = 0, falls = 0, n;
  // master clock
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  // pin wire: driven bits from the block, the rest from outside
  assign pins = (g_oe & g_out) | (~g_oe & ext);
  // count falling edges of ready
  always @(posedge mclk)
  begin
    rdy_q <= rdy_n;
    if (rdy_q === 1'b1 && rdy_n === 1'b0) falls++;
  end
  afr_readout_ctrl #(.SETTLE_R6(17'(SETTLE)), .WAKE_CYCLES(17'd20)) dut (
    .MCLK(mclk), .RESET(reset), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .DOUT(dout), .DOUT_OE(oe), .CONVERSION_READY_N(rdy_n),
    .START(start), .POWER_DOWN_N(pd_n), .CHANNEL_DATA(chan),
    .CHANNEL_ENABLE(en), .ELECTRODE_OFF_POS_FLAGS(pos),
    .ELECTRODE_OFF_NEG_FLAGS(neg), .GPIO_IN(pins), .GPIO_OUT(g_out),
    .GPIO_OE(g_oe), .GPIO_WRITE(gw), .GPIO_DIR_WDATA(dir_wd),
    .GPIO_LEVEL_WDATA(lvl_wd), .CONFIG_ONE_WRITE(w1),
    .CONFIG_FOUR_WRITE(w4), .BREATHING_WRITE(wb), .REG_WDATA(wd),
    .PIN_DIRECTION_BITS(dir), .PIN_LEVEL_BITS(lvl), .CONFIG_REG_ONE(c1),
    .CONFIG_REG_FOUR(c4), .BREATHING_CTRL(br), .CONVERTING(conv),
    .POWERED_DOWN(pdd));
  afr_host_model host (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .rx(rx));
  // compare and count
  task automatic chk(input string s, input logic [159:0] e, g);
    comparisons++;
    if (e !== g)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // register strobe: 0 config one, 1 config four, 2 breathing
  task automatic register_write_cmd(input int s, input logic [7:0] d);
    wd <= d;
    w1 <= (s == 0);
    w4 <= (s == 1);
    wb <= (s == 2);
    tick(1);
    {w1, w4, wb} <= 3'h0;
    tick(1);
  endtask
  // expected frame: head, flags, pin levels, enabled channels
  function automatic logic [151:0] frame(input afr_pkg::afr_chan_type c,
    input logic [7:0] e, p, q, input logic [3:0] g);
    logic [151:0] f;
    f = {4'hC, p, q, g, 128'h0};
    for (int i = 0; i < 8; i++)
      if (e[i])
        f[16*i +: 16] = c[i];
    return f;
  endfunction
  // one-shot conversion of random data, then a 160-bit read
  task automatic shot(input logic chain);
    chan <= {$urandom, $urandom, $urandom, $urandom};
    {en, pos, neg} <= 24'($urandom);
    tick(1);
    start <= 1'b1;
    n = 0;
    while (rdy_n !== 1'b0 && n < 4000)
    begin
      tick(1);
      n++;
    end
    chk("settle", 1'b1, n >= SETTLE && n <= SETTLE + 10);
    tick(200);
    chk("hold", 2'b00, {rdy_n, conv});
    ef = frame(chan, en, pos, neg, pins);
    host.xfer(8'h00, 160);
    tick(1);
    chk("frame", {ef, chain ? ef[151:144] : 8'h00}, rx);
    chk("ready", 1'b1, rdy_n);
    start <= 1'b0;
    tick(4);
  endtask
  // main sequence
  initial
  begin
    void'($urandom(69));
    tick(10);
    reset <= 1'b0;
    tick(2);
    chk("reset", {4'hF, 4'h0, 8'h06}, {dir, g_oe, c1});
    repeat (8)
    begin
      {dir_wd, lvl_wd, ext} <= 12'($urandom);
      gw <= 1'b1;
      tick(1);
      gw <= 1'b0;
      tick(8);
      chk("oe", 4'hF, g_oe ^ dir_wd);
      chk("out", lvl_wd & ~dir_wd, g_out & ~dir_wd);
      chk("level", pins, lvl);
      mo = (lvl_wd & ~dir_wd) | (mo & dir_wd);
      chk("keep", mo, g_out);
    end
    start <= 1'b1;
    tick(1);
    start <= 1'b0;
    tick(100);
    chk("idle", 2'b10, {rdy_n, conv});
    register_write_cmd(2, 8'h5A);
    chk("breath", 8'h5A, br);
    register_write_cmd(1, 8'h08);
    shot(1'b0);
    register_write_cmd(0, 8'h46);
    shot(1'b1);
    register_write_cmd(1, 8'h00);
    host.xfer(8'h12, 8);
    host.xfer(8'h10, 8);
    tick(1);
    falls = 0;
    tick(120);
    chk("run", 1'b1, falls >= 3);
    host.xfer(8'h12, 8);
    tick(1);
    falls = 0;
    tick(100);
    chk("stop", 1'b1, falls <= 1 && conv === 1'b0);
    register_write_cmd(0, 8'h45);
    host.xfer(8'h16, 8);
    tick(30);
    chk("rst op", {8'h06, 8'h00, 8'h00, 4'hF}, {c1, c4, br, dir});
    pd_n <= 1'b0;
    tick(12);
    chk("pd", 2'b10, {pdd, conv});
    pd_n <= 1'b1;
    tick(60);
    chk("wake", 1'b0, pdd);
    end_of_test();
  end
  // hang guard
  initial
  begin
    #1000000;
    errors++;
    end_of_test();
  end
endmodule
